// file: rtl/adcpr_consts.svh
// Constants for the converter parallel readout port and its host reader.
`ifndef ADCPR_CONSTS_SVH
`define ADCPR_CONSTS_SVH

`define ADCPR_DATA_W 16
`define ADCPR_SEL_W 3
`define ADCPR_MAX_LEVEL 7
`define ADCPR_WORD_CLKS 8
`define ADCPR_HALF_CLKS 4
`define ADCPR_SETTLE_CYC 47
`define ADCPR_WARM_WORDS 1
`define ADCPR_PRIME_CYC 8
`define ADCPR_QUIET_CYC 8
`define ADCPR_RD_GUARD_CYC 2
`define ADCPR_CLK_NS 50
`define ADCPR_RST_MIN_NS 50
`define ADCPR_RST_CYC \
  ((`ADCPR_RST_MIN_NS + `ADCPR_CLK_NS - 1) / `ADCPR_CLK_NS)
`define ADCPR_POS_FS 16'h7fff
`define ADCPR_NEG_FS 16'h8000
`define ADCPR_BUS_RST 16'h0000

`endif

// file: rtl/adcpr_pkg.sv
// Types shared by the readout port ends.
`default_nettype none
`include "adcpr_consts.svh"

package adcpr_pkg;

  typedef logic [`ADCPR_DATA_W-1:0] adcpr_word_type;
  typedef logic [`ADCPR_SEL_W-1:0] adcpr_sel_type;

  typedef enum logic [3:0] {
    H_IDLE = 4'h0,
    H_RESET = 4'h1,
    H_PRIME = 4'h2,
    H_WAIT = 4'h3,
    H_SEL = 4'h4,
    H_RDLOW = 4'h5,
    H_RDHIGH = 4'h6,
    H_END = 4'h7
  } adcpr_hstate_type;

endpackage : adcpr_pkg

`default_nettype wire

// file: rtl/adcpr_if.sv
// Pin bundle between the converter readout port and its host.
`timescale 1ns/10ps
`default_nettype none
`include "adcpr_consts.svh"

interface adcpr_if;
  logic conv_reset_n;
  logic rd_n;
  logic cs_n;
  logic buf_en;
  adcpr_pkg::adcpr_sel_type buffer_depth_sel;
  logic sample_ready_n;
  logic overrange_flag;
  adcpr_pkg::adcpr_word_type bus_q;
  logic bus_oe;
  adcpr_pkg::adcpr_word_type bus_d;

  // A released bus is seen as zero; no floating value exists here.
  assign bus_d = bus_oe ? bus_q : `ADCPR_BUS_RST;

  modport dev (
    input conv_reset_n, rd_n, cs_n, buf_en, buffer_depth_sel,
    output sample_ready_n, overrange_flag, bus_q, bus_oe
  );

  modport host (
    output conv_reset_n, rd_n, cs_n, buf_en, buffer_depth_sel,
    input sample_ready_n, overrange_flag, bus_d
  );
endinterface : adcpr_if

`default_nettype wire

// file: rtl/adcpr_skid.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none

module adcpr_skid #(
  parameter int W = 16
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem [0:1];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_reg];

  always_comb begin
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Flags are registered so that both handshake outputs come from flops.
  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg ^ push;
      rd_ptr_reg <= rd_ptr_reg ^ pop;
      cnt_reg <= cnt_next;
      in_ready <= (cnt_next != 2'h2);
      out_valid <= (cnt_next != 2'h0);
    end
  end
endmodule : adcpr_skid

`default_nettype wire

// file: rtl/adcpr_device.sv
// Converter end of the parallel sample readout port.
//
// Function
// - Unbuffered ready high four, low four clocks.
// - Ready falls only on a rising clock.
// - Bus driven the clock after read and select are sampled low.
// - Reset forces ready high and bus low.
// - Words unsettled until 47 ready cycles pass.
// - Buffered ready high one clock per period.
// - Each buffered period releases level-count words.
// - Host ends reads two clocks before toggle.
// - Host selects no later than read falls.
// - Host raises read no later than deselect.
// - Host holds read low eight clocks after reset.
// - Host read high eight before first pulse.
// - Level comes from static three-bit selection.
// - Bus bit fifteen is the most significant.
// - Samples two's complement, clamped 7fff/8000.
// - Overrange output high when input exceeds range.
`timescale 1ns/10ps
`default_nettype none
`include "adcpr_consts.svh"

module adcpr_device #(
  parameter int RAW_W = 18,
  parameter int DEPTH = `ADCPR_MAX_LEVEL
) (
  input wire logic mclk,
  input wire logic srst,
  adcpr_if.dev link,
  input wire logic signed [RAW_W-1:0] sample_raw,
  output logic settled
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // A zero selection would give an empty period, so it acts as one.
  function automatic logic [2:0] eff_level(input logic [2:0] sel);
    eff_level = (sel == 3'h0) ? 3'h1 : sel;
  endfunction : eff_level

  function automatic logic is_over(input logic signed [RAW_W-1:0] raw);
    logic signed [RAW_W-1:0] hi;
    logic signed [RAW_W-1:0] lo;
    hi = RAW_W'(signed'(`ADCPR_POS_FS));
    lo = RAW_W'(signed'(`ADCPR_NEG_FS));
    is_over = (raw > hi) || (raw < lo);
  endfunction : is_over

  function automatic adcpr_pkg::adcpr_word_type clamp(
    input logic signed [RAW_W-1:0] raw
  );
    if (!is_over(raw)) begin
      clamp = raw[`ADCPR_DATA_W-1:0];
    end else if (raw[RAW_W-1]) begin
      clamp = `ADCPR_NEG_FS;
    end else begin
      clamp = `ADCPR_POS_FS;
    end
  endfunction : clamp

  // ****************************************************************
  // Reset and static selection
  // ****************************************************************

  logic rst_i;
  logic buf_en_reg;
  logic [2:0] level_reg;

  // The link reset is taken as synchronous to mclk like every pin.
  assign rst_i = srst | ~link.conv_reset_n;

  // The selection pins are static; they are caught while reset is low.
  always_ff @(posedge mclk) begin
    if (srst) begin
      buf_en_reg <= 1'b0;
      level_reg <= 3'h1;
    end else if (!link.conv_reset_n) begin
      buf_en_reg <= link.buf_en;
      level_reg <= eff_level(link.buffer_depth_sel);
    end
  end

  // ****************************************************************
  // Word rate divider
  // ****************************************************************

  logic [2:0] wcnt_reg;
  logic tick;
  logic half;

  assign tick = (wcnt_reg == 3'(`ADCPR_WORD_CLKS - 1));
  assign half = (wcnt_reg == 3'(`ADCPR_HALF_CLKS - 1));

  always_ff @(posedge mclk) begin
    if (rst_i) begin
      wcnt_reg <= 3'h0;
    end else begin
      wcnt_reg <= wcnt_reg + 3'h1;
    end
  end

  // ****************************************************************
  // Sample shaping
  // ****************************************************************

  adcpr_pkg::adcpr_word_type hold_reg;
  logic ovr_reg;

  always_ff @(posedge mclk) begin
    if (rst_i) begin
      ovr_reg <= 1'b0;
    end else begin
      ovr_reg <= is_over(sample_raw);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst_i) begin
      hold_reg <= `ADCPR_BUS_RST;
    end else if (tick) begin
      hold_reg <= clamp(sample_raw);
    end
  end

  assign link.overrange_flag = ovr_reg;

  // ****************************************************************
  // Buffered capture
  // ****************************************************************

  adcpr_pkg::adcpr_word_type cap_mem [0:DEPTH-1];
  adcpr_pkg::adcpr_word_type out_mem [0:DEPTH-1];
  logic [2:0] cap_idx_reg;
  logic warm_reg;
  logic armed_reg;
  logic period_end;

  // The first word after reset is dropped as filter warm-up, which
  // pushes the first ready fall past eight clocks times level plus one.
  assign period_end = buf_en_reg & tick & warm_reg &
    (cap_idx_reg == level_reg - 3'h1);

  always_ff @(posedge mclk) begin
    if (rst_i) begin
      warm_reg <= 1'b0;
      cap_idx_reg <= 3'h0;
    end else if (buf_en_reg && tick) begin
      if (!warm_reg) begin
        warm_reg <= 1'b1;
      end else if (period_end) begin
        cap_idx_reg <= 3'h0;
      end else begin
        cap_idx_reg <= cap_idx_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (buf_en_reg && tick && warm_reg) begin
      cap_mem[cap_idx_reg] <= clamp(sample_raw);
    end
  end

  // The newest word bypasses cap_mem, whose slot is written this edge.
  always_ff @(posedge mclk) begin
    if (period_end) begin
      for (int i = 0; i < DEPTH; i++) begin
        out_mem[i] <= (3'(i) == cap_idx_reg) ?
          clamp(sample_raw) : cap_mem[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst_i) begin
      armed_reg <= 1'b0;
    end else if (period_end) begin
      armed_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // Ready strobe
  // ****************************************************************

  logic ready_reg;
  logic ready_prev_reg;

  always_ff @(posedge mclk) begin
    if (rst_i) begin
      ready_reg <= 1'b1;
    end else if (!buf_en_reg) begin
      if (tick) begin
        ready_reg <= 1'b0;
      end else if (half) begin
        ready_reg <= 1'b1;
      end
    end else if (period_end) begin
      ready_reg <= 1'b1;
    end else if (armed_reg) begin
      ready_reg <= 1'b0;
    end
  end

  assign link.sample_ready_n = ready_reg;

  // ****************************************************************
  // Read pointer and bus drive
  // ****************************************************************

  logic rd_prev_reg;
  logic rd_rise;
  logic [2:0] ptr_reg;
  adcpr_pkg::adcpr_word_type bus_q_reg;
  logic bus_oe_reg;

  // A word is consumed when read returns high with select still low.
  assign rd_rise = ~rd_prev_reg & link.rd_n & ~link.cs_n;

  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_prev_reg <= 1'b1;
    end else begin
      rd_prev_reg <= link.rd_n;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst_i || period_end) begin
      ptr_reg <= 3'h0;
    end else if (rd_rise && (ptr_reg != level_reg - 3'h1)) begin
      ptr_reg <= ptr_reg + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      bus_oe_reg <= 1'b0;
    end else begin
      bus_oe_reg <= ~link.rd_n & ~link.cs_n;
    end
  end

  // Bit 15 of the word is bit 15 of the bus.
  always_ff @(posedge mclk) begin
    if (rst_i) begin
      bus_q_reg <= `ADCPR_BUS_RST;
    end else if (buf_en_reg) begin
      bus_q_reg <= out_mem[ptr_reg];
    end else begin
      bus_q_reg <= hold_reg;
    end
  end

  assign link.bus_q = bus_q_reg;
  assign link.bus_oe = bus_oe_reg;

  // ****************************************************************
  // Settling count
  // ****************************************************************

  logic [5:0] settle_cnt_reg;

  always_ff @(posedge mclk) begin
    if (rst_i) begin
      ready_prev_reg <= 1'b1;
    end else begin
      ready_prev_reg <= ready_reg;
    end
  end

  // Words before this point are filter transients and must not be used.
  always_ff @(posedge mclk) begin
    if (rst_i) begin
      settle_cnt_reg <= 6'h0;
      settled <= 1'b0;
    end else if (ready_prev_reg && !ready_reg && !settled) begin
      settle_cnt_reg <= settle_cnt_reg + 6'h1;
      settled <= (settle_cnt_reg == 6'(`ADCPR_SETTLE_CYC - 1));
    end
  end

endmodule : adcpr_device

`default_nettype wire

// file: rtl/adcpr_host.sv
// Host end that resets the converter and drains its sample bus.
`timescale 1ns/10ps
`default_nettype none
`include "adcpr_consts.svh"

module adcpr_host (
  input wire logic mclk,
  input wire logic srst,
  adcpr_if.host link,
  input wire logic reset_req,
  input wire logic cfg_buf_en,
  input wire logic [2:0] cfg_depth_sel,
  output logic word_valid,
  input wire logic word_ready,
  output logic [`ADCPR_DATA_W-1:0] word_data,
  output logic overrange_seen
);

  // ****************************************************************
  // Sequencer
  // ****************************************************************

  adcpr_pkg::adcpr_hstate_type st_reg;
  logic rst_n_reg;
  logic rd_n_reg;
  logic cs_n_reg;
  logic [5:0] cnt_reg;
  logic [5:0] age_reg;
  logic [2:0] left_reg;
  logic [2:0] level;
  logic ready_prev_reg;
  logic fall;
  logic late;
  logic push;
  logic buf_ready;

  assign level = (cfg_depth_sel == 3'h0) ? 3'h1 : cfg_depth_sel;
  assign fall = ready_prev_reg & ~link.sample_ready_n;
  // No new read may start once it could end inside the guard window.
  assign late = cfg_buf_en && (age_reg + 6'h4 >
    6'({level, 3'h0} - 6'(`ADCPR_RD_GUARD_CYC) - 6'h1));
  assign push = (st_reg == adcpr_pkg::H_RDLOW) && (cnt_reg == 6'h1);

  assign link.conv_reset_n = rst_n_reg;
  assign link.rd_n = rd_n_reg;
  assign link.cs_n = cs_n_reg;
  assign link.buf_en = cfg_buf_en;
  assign link.buffer_depth_sel = cfg_depth_sel;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ready_prev_reg <= 1'b1;
      age_reg <= 6'h0;
      overrange_seen <= 1'b0;
    end else begin
      ready_prev_reg <= link.sample_ready_n;
      age_reg <= fall ? 6'h0 : age_reg + {5'h0, age_reg != 6'h3f};
      overrange_seen <= link.overrange_flag;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg <= adcpr_pkg::H_IDLE;
      rst_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      cs_n_reg <= 1'b1;
      cnt_reg <= 6'h0;
      left_reg <= 3'h0;
    end else begin
      unique case (st_reg)
        adcpr_pkg::H_IDLE: begin
          if (reset_req) begin
            st_reg <= adcpr_pkg::H_RESET;
            rst_n_reg <= 1'b0;
            rd_n_reg <= ~cfg_buf_en;
            cnt_reg <= 6'h0;
          end
        end
        adcpr_pkg::H_RESET: begin
          cnt_reg <= cnt_reg + 6'h1;
          if (cnt_reg == 6'(`ADCPR_RST_CYC - 1)) begin
            rst_n_reg <= 1'b1;
            cnt_reg <= 6'h0;
            st_reg <= cfg_buf_en ? adcpr_pkg::H_PRIME : adcpr_pkg::H_WAIT;
          end
        end
        adcpr_pkg::H_PRIME: begin
          cnt_reg <= cnt_reg + 6'h1;
          if (cnt_reg == 6'(`ADCPR_PRIME_CYC - 1)) begin
            rd_n_reg <= 1'b1;
            st_reg <= adcpr_pkg::H_WAIT;
          end
        end
        adcpr_pkg::H_WAIT: begin
          if (reset_req) begin
            st_reg <= adcpr_pkg::H_IDLE;
          end else if (fall && buf_ready) begin
            cs_n_reg <= 1'b0;
            left_reg <= cfg_buf_en ? level : 3'h1;
            st_reg <= adcpr_pkg::H_SEL;
          end
        end
        adcpr_pkg::H_SEL: begin
          rd_n_reg <= 1'b0;
          cnt_reg <= 6'h0;
          st_reg <= adcpr_pkg::H_RDLOW;
        end
        adcpr_pkg::H_RDLOW: begin
          cnt_reg <= cnt_reg + 6'h1;
          if (push) begin
            rd_n_reg <= 1'b1;
            left_reg <= left_reg - 3'h1;
            st_reg <= adcpr_pkg::H_RDHIGH;
          end
        end
        adcpr_pkg::H_RDHIGH: begin
          if (left_reg == 3'h0 || late) begin
            st_reg <= adcpr_pkg::H_END;
          end else if (buf_ready) begin
            rd_n_reg <= 1'b0;
            cnt_reg <= 6'h0;
            st_reg <= adcpr_pkg::H_RDLOW;
          end
        end
        adcpr_pkg::H_END: begin
          cs_n_reg <= 1'b1;
          st_reg <= adcpr_pkg::H_WAIT;
        end
        default: begin
          st_reg <= adcpr_pkg::H_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Output buffer
  // ****************************************************************

  // A stalled consumer delays the next read rather than losing a word.
  adcpr_skid #(
    .W(`ADCPR_DATA_W)
  ) adcpr_skid_inst (
    .mclk(mclk),
    .srst(srst),
    .in_valid(push),
    .in_ready(buf_ready),
    .in_data(link.bus_d),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data(word_data)
  );

endmodule : adcpr_host

`default_nettype wire

// file: verification/adcpr_monitor.sv
// Pin-level checker for the readout port between its two ends.
`timescale 1ns/10ps
`default_nettype none

module adcpr_monitor (
  input wire logic mclk,
  input wire logic srst,
  input wire logic conv_reset_n,
  input wire logic rd_n,
  input wire logic cs_n,
  input wire logic buf_en,
  input wire adcpr_pkg::adcpr_sel_type buffer_depth_sel,
  input wire logic sample_ready_n,
  input wire adcpr_pkg::adcpr_word_type bus_q,
  input wire logic bus_oe
);
  // ********************************************************************
  // Helper counters
  // ********************************************************************
  logic ready_q;
  logic seen_fall;
  logic [7:0] per_cnt;
  logic [7:0] since_rel;
  logic [7:0] rd_hi_cnt;
  int lvl;

  // A level of zero behaves as one.
  assign lvl = (buffer_depth_sel == 3'h0) ? 1 : int'(buffer_depth_sel);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  always_ff @(posedge mclk) begin
    ready_q <= sample_ready_n;
  end

  always_ff @(posedge mclk) begin
    if (ready_q && !sample_ready_n) begin
      per_cnt <= 8'h01;
    end else if (per_cnt != 8'hff) begin
      per_cnt <= per_cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || !conv_reset_n) begin
      since_rel <= 8'h00;
    end else if (since_rel != 8'hff) begin
      since_rel <= since_rel + 8'h01;
    end
  end

  // Counts consecutive clocks with read high, saturating.
  always_ff @(posedge mclk) begin
    if (srst || !rd_n) begin
      rd_hi_cnt <= 8'h00;
    end else if (rd_hi_cnt != 8'hff) begin
      rd_hi_cnt <= rd_hi_cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || !conv_reset_n) begin
      seen_fall <= 1'b0;
    end else if (ready_q && !sample_ready_n) begin
      seen_fall <= 1'b1;
    end
  end

  // ********************************************************************
  // Properties
  // ********************************************************************
  property p_bus_gate;
    !$past(srst) |-> bus_oe == $past(!rd_n && !cs_n);
  endproperty
  a_bus_gate: assert property (p_bus_gate)
    else $error("bus enable does not follow read and select");

  property p_conv_reset;
    !conv_reset_n |=> sample_ready_n && bus_q == 16'h0000;
  endproperty
  a_conv_reset: assert property (p_conv_reset)
    else $error("reset does not force ready high and bus low");

  property p_plain_duty;
    disable iff (srst || !conv_reset_n)
    !buf_en && $fell(sample_ready_n) |->
      !sample_ready_n[*4] ##1 sample_ready_n[*4] ##1 !sample_ready_n;
  endproperty
  a_plain_duty: assert property (p_plain_duty)
    else $error("unbuffered ready phases are not four clocks");

  property p_buf_period;
    disable iff (srst || !conv_reset_n)
    buf_en && $fell(sample_ready_n) && seen_fall |-> per_cnt == 8 * lvl;
  endproperty
  a_buf_period: assert property (p_buf_period)
    else $error("buffered ready period is not eight times the level");

  property p_buf_high;
    disable iff (srst || !conv_reset_n)
    buf_en && $fell(sample_ready_n) && seen_fall |->
      !$past(sample_ready_n, 2);
  endproperty
  a_buf_high: assert property (p_buf_high)
    else $error("buffered ready high phase is not one clock");

  property p_first_fall;
    disable iff (srst || !conv_reset_n)
    buf_en && $fell(sample_ready_n) && !seen_fall |->
      since_rel >= 8 * (lvl + 1) && since_rel <= 8 * (lvl + 1) + 8;
  endproperty
  a_first_fall: assert property (p_first_fall)
    else $error("first buffered ready fall at the wrong time");

  property p_rd_guard;
    disable iff (srst || !conv_reset_n)
    buf_en && $changed(sample_ready_n) && $past(conv_reset_n) |->
      $past(rd_n, 1) && $past(rd_n, 2);
  endproperty
  a_rd_guard: assert property (p_rd_guard)
    else $error("read low too close to a ready change");

  property p_sel_first;
    buf_en && seen_fall && $fell(rd_n) |-> !cs_n;
  endproperty
  a_sel_first: assert property (p_sel_first)
    else $error("read fell before select");

  property p_rd_last;
    buf_en && seen_fall && $rose(cs_n) |-> rd_n;
  endproperty
  a_rd_last: assert property (p_rd_last)
    else $error("select released while read low");

  property p_rd_prime;
    buf_en && $rose(conv_reset_n) |=> !rd_n[*7];
  endproperty
  a_rd_prime: assert property (p_rd_prime)
    else $error("read not held low after reset release");

  property p_rd_quiet;
    disable iff (srst || !conv_reset_n)
    buf_en && $fell(sample_ready_n) && !seen_fall |-> rd_hi_cnt >= 8'h08;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read not high long enough before the first ready fall");
endmodule : adcpr_monitor

`default_nettype wire

// file: verification/adcpr_tb.sv
// Self-checking bench with both ends of the readout port joined.
`timescale 1ns/10ps
`default_nettype none

module adcpr_tb;
  logic mclk;
  logic srst;
  logic reset_req;
  logic cfg_buf_en;
  logic [2:0] cfg_depth_sel;
  logic word_valid;
  logic word_ready;
  logic [15:0] word_data;
  logic overrange_seen;
  logic settled;
  logic signed [17:0] sample_raw;
  logic prev_rdy;
  logic [15:0] d;
  int mismatches;
  int cmp_count;
  int pushes;
  int last_burst;
  int nfall;
  logic [17:0] raw_tab [6];
  logic [15:0] exp_tab [6];
  logic ovr_tab [6];
  logic [2:0] lvl_tab [5];
  logic [15:0] burst_tab [5];

  adcpr_if adcpr_if_inst ();

  adcpr_device #(.RAW_W(18), .DEPTH(7)) adcpr_device_inst (
    .mclk(mclk), .srst(srst), .link(adcpr_if_inst),
    .sample_raw(sample_raw), .settled(settled));

  adcpr_host adcpr_host_inst (
    .mclk(mclk), .srst(srst), .link(adcpr_if_inst),
    .reset_req(reset_req), .cfg_buf_en(cfg_buf_en),
    .cfg_depth_sel(cfg_depth_sel), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data),
    .overrange_seen(overrange_seen));

  adcpr_monitor adcpr_monitor_inst (
    .mclk(mclk), .srst(srst),
    .conv_reset_n(adcpr_if_inst.conv_reset_n),
    .rd_n(adcpr_if_inst.rd_n), .cs_n(adcpr_if_inst.cs_n),
    .buf_en(adcpr_if_inst.buf_en),
    .buffer_depth_sel(adcpr_if_inst.buffer_depth_sel),
    .sample_ready_n(adcpr_if_inst.sample_ready_n),
    .bus_q(adcpr_if_inst.bus_q), .bus_oe(adcpr_if_inst.bus_oe));

  // ********************************************************************
  // Clock, watchdog and burst counter
  // ********************************************************************
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    #(60000 * 50);
    mismatches = mismatches + 1;
    summarize();
  end

  // Words handed to the user between two ready falls form one burst.
  always @(posedge mclk) begin
    prev_rdy <= adcpr_if_inst.sample_ready_n;
    if (prev_rdy === 1'b1 && adcpr_if_inst.sample_ready_n === 1'b0) begin
      last_burst <= pushes;
      pushes <= (word_valid === 1'b1 && word_ready === 1'b1) ? 1 : 0;
    end else if (word_valid === 1'b1 && word_ready === 1'b1) begin
      pushes <= pushes + 1;
    end
  end

  // ********************************************************************
  // Tasks
  // ********************************************************************
  task automatic summarize();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic start(input logic buf_mode, input logic [2:0] lvl);
    @(negedge mclk);
    srst = 1'b1;
    cfg_buf_en = buf_mode;
    cfg_depth_sel = lvl;
    repeat (20) @(negedge mclk);
    srst = 1'b0;
    reset_req = 1'b1;
    @(negedge mclk);
    reset_req = 1'b0;
  endtask : start

  // The user side accepts each word at the edge after it is seen.
  task automatic read_word(output logic [15:0] w);
    int n;
    n = 0;
    @(negedge mclk);
    while (word_valid !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n = n + 1;
    end
    if (n >= 3000) begin
      mismatches = mismatches + 1;
      summarize();
    end
    w = word_data;
  endtask : read_word

  task automatic wait_fall();
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n = n + 1;
    end while (!(prev_rdy === 1'b1 && adcpr_if_inst.sample_ready_n === 1'b0)
               && n < 1000);
    if (n >= 1000) begin
      mismatches = mismatches + 1;
      summarize();
    end
  endtask : wait_fall

  // Older words still in flight are dropped before each compare.
  task automatic run_values(input int flush);
    logic [15:0] w;
    for (int i = 0; i < 6; i++) begin
      @(negedge mclk);
      sample_raw = raw_tab[i];
      repeat (flush) read_word(w);
      read_word(w);
      check(w, exp_tab[i]);
      check({15'h0000, overrange_seen}, {15'h0000, ovr_tab[i]});
    end
  endtask : run_values

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    srst = 1'b1;
    reset_req = 1'b0;
    cfg_buf_en = 1'b0;
    cfg_depth_sel = 3'h1;
    word_ready = 1'b1;
    sample_raw = 18'h00000;
    mismatches = 0;
    cmp_count = 0;
    pushes = 0;
    last_burst = 0;
    raw_tab = '{18'h01234, 18'h3edcc, 18'h07fff, 18'h38000, 18'h1ffff,
                18'h20000};
    exp_tab = '{16'h1234, 16'hedcc, 16'h7fff, 16'h8000, 16'h7fff, 16'h8000};
    ovr_tab = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    lvl_tab = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h7};
    burst_tab = '{16'h0001, 16'h0001, 16'h0003, 16'h0004, 16'h0007};
    start(1'b0, 3'h1);
    nfall = 0;
    // The settled flag is registered one clock after the counted fall.
    do begin
      wait_fall();
      nfall = nfall + 1;
      @(negedge mclk);
    end while (settled !== 1'b1 && nfall < 60);
    check(16'(nfall), 16'h002f);
    run_values(4);
    foreach (lvl_tab[j]) begin
      start(1'b1, lvl_tab[j]);
      run_values(2 * int'(burst_tab[j]) + 4);
      wait_fall();
      wait_fall();
      check(16'(last_burst), burst_tab[j]);
    end
    // A long user stall must leave the held word in place.
    @(negedge mclk);
    word_ready = 1'b0;
    repeat (200) @(negedge mclk);
    check({15'h0000, word_valid}, 16'h0001);
    check(word_data, 16'h8000);
    word_ready = 1'b1;
    read_word(d);
    check(d, 16'h8000);
    summarize();
  end
endmodule : adcpr_tb

`default_nettype wire
